// File: hw/scs_top.sv
`timescale 1ns/1ps
// system clock source selector; core clock is produced as a registered toggle
// divided from MCLK, modelling the internal oscillator as MCLK itself
module scs_top (
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic [6:0] TRIM_STRAP,
  input  wire logic       XTAL_B_IN,
  output logic            CORE_CLK_OUT,
  output logic            EXT_CLK_OUT,
  output logic            XTAL_A_CLAIM,
  output logic            XTAL_B_CLAIM,
  output logic [2:0]      EXT_FREQ_CTRL,
  output logic            INT_OSC_ON,
  output logic [6:0]      INT_TRIM
);
  import scs_pkg::*;

  logic [7:0] ictl_reg, ictl_next;
  logic [6:0] trim_reg, trim_next;
  logic [7:0] xctl_reg, xctl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       trim_ld_reg, trim_ld_next;
  logic [4:0] istart_reg, istart_next;
  logic       irdy_reg, irdy_next;
  logic [7:0] xset_reg, xset_next;
  logic       xvld_reg, xvld_next;
  logic       xhalf_reg, xhalf_next;
  logic       xseen_reg, xseen_next;
  logic [2:0] div_reg, div_next;
  logic       cclk_reg, cclk_next;
  logic       eclk_reg, eclk_next;
  logic       asel_reg, asel_next;
  logic [1:0] adiv_reg, adiv_next;
  scs_sw_t    sw_reg, sw_next;
  logic       a_claim_reg, a_claim_next;
  logic       b_claim_reg, b_claim_next;

  logic       x_level;
  logic       x_edge;
  logic [2:0] xmode;
  logic       xtal_mode;
  logic       ext_on;
  logic       ext_tick;
  logic       int_tick;
  logic       cur_tick;

  // crystal terminal b sampled through three stages
  scs_edge_sync u_xsync (
    .MCLK  (MCLK),
    .RST_N (RST_N),
    .din   (XTAL_B_IN),
    .level (x_level),
    .rise  ()
  );
  // pin edge marked against its own copy, so the halving stage sees each edge once
  assign x_edge = x_level ^ xseen_reg;

  assign xmode     = xctl_reg[6:4];
  assign xtal_mode = (xmode == XM_XTAL) || (xmode == XM_XTAL_D2);
  assign ext_on    = xmode[2] | xmode[1];

  // mode decode, halving stage on odd modes from 3 up and all RC/cap modes
  always_comb begin
    ext_tick = 1'b0;
    unique case (xmode)
      XM_CMOS, XM_XTAL:  ext_tick = x_edge;
      XM_CMOS_D2, XM_RC_D2, XM_CAP_D2, XM_XTAL_D2:
                         ext_tick = x_edge & xhalf_reg;
      default:           ext_tick = 1'b0;
    endcase
  end

  // register file; writes masked so unused bits stay zero
  always_comb begin
    ictl_next    = ictl_reg;
    trim_next    = trim_reg;
    xctl_next    = xctl_reg;
    trim_ld_next = 1'b1;
    rdata_next   = 8'h00;
    // per-device trim caught from strap just after reset release
    if (!trim_ld_reg) begin
      trim_next = TRIM_STRAP;
    end
    if (WR) begin
      unique case (ADDR)
        // enable and select taken together in one write
        ADDR_INT_CTRL: ictl_next = WDATA & INT_CTRL_WMASK;
        ADDR_INT_TRIM: trim_next = WDATA[6:0] & TRIM_WMASK[6:0];
        // reserved bit 3 ignored; range field stored
        ADDR_EXT_CTRL: xctl_next = WDATA & EXT_CTRL_WMASK;
        default:       ictl_next = ictl_reg;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        // ready flag shows the oscillator state
        ADDR_INT_CTRL: rdata_next = ictl_reg | {3'h0, irdy_reg, 4'h0};
        ADDR_INT_TRIM: rdata_next = {1'b0, trim_reg};
        // valid flag only while in a crystal mode
        ADDR_EXT_CTRL: rdata_next = xctl_reg | {xvld_reg & xtal_mode, 7'h00};
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  // oscillator status: internal start-up and crystal settle
  always_comb begin
    istart_next = istart_reg;
    irdy_next   = irdy_reg;
    xset_next   = xset_reg;
    xvld_next   = xvld_reg;
    xhalf_next  = xhalf_reg;
    eclk_next   = eclk_reg;
    xseen_next  = x_level;
    // enable bit gates the internal oscillator
    if (!ictl_reg[BIT_EN]) begin
      istart_next = 5'h0;
      irdy_next   = 1'b0;
    end else if (istart_reg != INT_START_CNT) begin
      istart_next = istart_reg + 5'h1;
    end else begin
      irdy_next = 1'b1;
    end
    if (x_edge) begin
      xhalf_next = ~xhalf_reg;
    end
    if (ext_tick) begin
      eclk_next = ~eclk_reg;
    end else if (!ext_on) begin
      eclk_next = 1'b0;
    end
    // settle counts external edges while a crystal mode is on
    if (!xtal_mode) begin
      xset_next = 8'h00;
      xvld_next = 1'b0;
    end else if (x_edge) begin
      if (xset_reg == XTAL_SETTLE) begin
        xvld_next = 1'b1;
      end else begin
        xset_next = xset_reg + 8'h01;
      end
    end
  end

  // divisor from the applied divide field
  always_comb begin
    int_tick = 1'b0;
    unique case (adiv_reg)
      DIV_BY8: int_tick = (div_reg == DIV_CNT_MAX);
      DIV_BY4: int_tick = (div_reg[1:0] == DIV_CNT_MAX[1:0]);
      DIV_BY2: int_tick = div_reg[0];
      DIV_BY1: int_tick = 1'b1;
    endcase
  end
  assign cur_tick = asel_reg ? ext_tick : int_tick;

  // changes applied only while the output is low, after a full period
  always_comb begin
    sw_next   = sw_reg;
    asel_next = asel_reg;
    adiv_next = adiv_reg;
    div_next  = div_reg + 3'h1;
    cclk_next = cclk_reg;
    unique case (sw_reg)
      SCS_RUN: begin
        if (cur_tick) begin
          cclk_next = ~cclk_reg;
        end
        if ((ictl_reg[BIT_SEL] != asel_reg || ictl_reg[1:0] != adiv_reg)
            && cur_tick && cclk_reg) begin
          sw_next = SCS_PARK;
        end
      end
      SCS_PARK: begin
        // source select applied; firmware picks a settled source
        asel_next = ictl_reg[BIT_SEL];
        adiv_next = ictl_reg[1:0];
        div_next  = 3'h0;
        sw_next   = SCS_RESUM;
      end
      SCS_RESUM: begin
        sw_next = SCS_RUN;
      end
      default: sw_next = SCS_RUN;
    endcase
  end

  // pin claims follow the external mode
  always_comb begin
    a_claim_next = ext_on & xtal_mode;
    b_claim_next = ext_on;
  end

  // reset selects internal source divided by 8
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ictl_reg    <= INT_CTRL_RST & INT_CTRL_WMASK;
      trim_reg    <= 7'h00;
      xctl_reg    <= EXT_CTRL_RST;
      rdata_reg   <= 8'h00;
      trim_ld_reg <= 1'b0;
      istart_reg  <= 5'h0;
      irdy_reg    <= 1'b0;
      xset_reg    <= 8'h00;
      xvld_reg    <= 1'b0;
      xhalf_reg   <= 1'b0;
      xseen_reg   <= 1'b0;
      eclk_reg    <= 1'b0;
      div_reg     <= 3'h0;
      cclk_reg    <= 1'b0;
      asel_reg    <= 1'b0;
      adiv_reg    <= DIV_BY8;
      sw_reg      <= SCS_RUN;
      a_claim_reg <= 1'b0;
      b_claim_reg <= 1'b0;
    end else begin
      ictl_reg    <= ictl_next;
      trim_reg    <= trim_next;
      xctl_reg    <= xctl_next;
      rdata_reg   <= rdata_next;
      trim_ld_reg <= trim_ld_next;
      istart_reg  <= istart_next;
      irdy_reg    <= irdy_next;
      xset_reg    <= xset_next;
      xvld_reg    <= xvld_next;
      xhalf_reg   <= xhalf_next;
      xseen_reg   <= xseen_next;
      eclk_reg    <= eclk_next;
      div_reg     <= div_next;
      cclk_reg    <= cclk_next;
      asel_reg    <= asel_next;
      adiv_reg    <= adiv_next;
      sw_reg      <= sw_next;
      a_claim_reg <= a_claim_next;
      b_claim_reg <= b_claim_next;
    end
  end

  // external clock offered to peripherals whenever the external circuit is on, held low when off
  assign EXT_CLK_OUT   = eclk_reg;
  assign CORE_CLK_OUT  = cclk_reg;
  assign RDATA         = rdata_reg;
  assign XTAL_A_CLAIM  = a_claim_reg;
  assign XTAL_B_CLAIM  = b_claim_reg;
  assign EXT_FREQ_CTRL = xctl_reg[2:0];
  assign INT_OSC_ON    = ictl_reg[BIT_EN];
  assign INT_TRIM      = trim_reg;

  // after reset the internal source is applied
  a_reset_source: assert property (@(posedge MCLK) $rose(RST_N) |-> !asel_reg)
    else $error("source not internal after reset");
  a_reset_div: assert property (@(posedge MCLK) $rose(RST_N) |-> adiv_reg == DIV_BY8)
    else $error("divide not eight after reset");
  a_ctrl_upper: assert property (@(posedge MCLK) disable iff (!RST_N)
    ictl_reg[7:5] == 3'h0)
    else $error("unused control bits set");
  a_trim_msb: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(RD) && $past(ADDR) == ADDR_INT_TRIM |-> !RDATA[7])
    else $error("trim bit 7 read as one");
  a_ext_resv: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(RD) && $past(ADDR) == ADDR_EXT_CTRL |-> !RDATA[3])
    else $error("reserved bit read as one");
  // valid never reported outside crystal modes
  a_valid_mode: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(RD) && $past(ADDR) == ADDR_EXT_CTRL && !$past(xtal_mode) |-> !RDATA[7])
    else $error("valid outside crystal mode");
  a_ready_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    !ictl_reg[BIT_EN] |=> !irdy_reg)
    else $error("ready while disabled");
  a_pin_claim: assert property (@(posedge MCLK) disable iff (!RST_N)
    xtal_mode |=> XTAL_A_CLAIM && XTAL_B_CLAIM)
    else $error("crystal pins not claimed");
  // selection only changes when output is low
  a_switch_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    asel_reg != $past(asel_reg) |-> !cclk_reg)
    else $error("switch while clock high");
  // a change parks the output low for two cycles before resuming
  sequence s_park;
    sw_reg == SCS_PARK && !cclk_reg;
  endsequence
  sequence s_resume;
    sw_reg == SCS_RESUM && !cclk_reg;
  endsequence
  a_switch_steps: assert property (@(posedge MCLK) disable iff (!RST_N)
    sw_reg == SCS_RUN && sw_next == SCS_PARK |=> s_park ##1 s_resume)
    else $error("switch steps out of order");
  // park applies the requested source and divisor
  a_sel_apply: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_park |=> asel_reg == $past(ictl_reg[BIT_SEL]) && adiv_reg == $past(ictl_reg[1:0]))
    else $error("requested source not applied");
  // ready follows a completed start-up count
  a_ready_on: assert property (@(posedge MCLK) disable iff (!RST_N)
    ictl_reg[BIT_EN] && istart_reg == INT_START_CNT |=> irdy_reg)
    else $error("ready missing after start-up");
  // circuit off holds the peripheral clock low
  a_ext_off: assert property (@(posedge MCLK) disable iff (!RST_N)
    !ext_on |=> !EXT_CLK_OUT)
    else $error("peripheral clock runs while off");
  // divide by one toggles the output every cycle
  a_div_one: assert property (@(posedge MCLK) disable iff (!RST_N)
    sw_reg == SCS_RUN && sw_next == SCS_RUN && !asel_reg && adiv_reg == DIV_BY1
    |=> cclk_reg != $past(cclk_reg))
    else $error("divide by one not toggling");
endmodule

// File: hw/scs_pkg.sv
// Notes on behaviour
// - after any reset the core clock runs from the internal oscillator.
// - internal divide field 00/01/10/11 selects divide by 8/4/2/1.
// - internal divide field resets to divide by 8.
// - source select bit 3: 0 scaled internal, 1 external circuit.
// - internal ready flag bit 4 reads 1 only while oscillator runs settled.
// - internal enable bit 2 turns the internal oscillator on or off.
// - trim register holds 7-bit trim; bit 7 reads zero, writes ignored.
// - trim loads a per-device value at reset, not a fixed constant.
// - one control write may enable and select the internal oscillator.
// - external oscillator stays available to peripherals whenever the external circuit is on.
// - crystal valid flag bit 7 read-only, set when settled, only in 11x.
// - external mode decodes off, CMOS, CMOS/2, RC/2, cap/2, crystal, crystal/2.
// - frequency control field 000-111 selects the external drive range.
// - crystal mode claims both crystal pins; other modes except off claim terminal b only.
// - external control bit 3 reserved, reads zero, writes ignored.
// - upper three bits of internal control read zero, writes ignored.
package scs_pkg;
  localparam logic [7:0] ADDR_INT_CTRL  = 8'hb2;
  localparam logic [7:0] ADDR_INT_TRIM  = 8'hb3;
  localparam logic [7:0] ADDR_EXT_CTRL  = 8'hb1;
  localparam logic [7:0] INT_CTRL_RST   = 8'h14;
  localparam logic [7:0] EXT_CTRL_RST   = 8'h00;
  localparam int         BIT_RDY        = 4;
  localparam int         BIT_SEL        = 3;
  localparam int         BIT_EN         = 2;
  localparam int         BIT_VALID      = 7;
  localparam logic [7:0] INT_CTRL_WMASK = 8'h0f;
  localparam logic [7:0] TRIM_WMASK     = 8'h7f;
  localparam logic [7:0] EXT_CTRL_WMASK = 8'h77;
  localparam logic [2:0] DIV_CNT_MAX    = 3'h7;
  localparam logic [1:0] DIV_BY8        = 2'h0;
  localparam logic [1:0] DIV_BY4        = 2'h1;
  localparam logic [1:0] DIV_BY2        = 2'h2;
  localparam logic [1:0] DIV_BY1        = 2'h3;
  localparam logic [2:0] XM_CMOS        = 3'h2;
  localparam logic [2:0] XM_CMOS_D2     = 3'h3;
  localparam logic [2:0] XM_RC_D2       = 3'h4;
  localparam logic [2:0] XM_CAP_D2      = 3'h5;
  localparam logic [2:0] XM_XTAL        = 3'h6;
  localparam logic [2:0] XM_XTAL_D2     = 3'h7;
  // internal oscillator start-up, given in ns and rounded up to clock cycles (modelled)
  localparam int         INT_START_NS   = 200;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         INT_START_CYC  = (INT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] INT_START_CNT  = 5'(INT_START_CYC);
  // crystal amplitude settling: count of external edges seen
  localparam logic [7:0] XTAL_SETTLE    = 8'hff;
  typedef enum logic [1:0] {
    SCS_RUN   = 2'b00,
    SCS_PARK  = 2'b01,
    SCS_RESUM = 2'b10
  } scs_sw_t;
endpackage

// File: hw/scs_edge_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts when stages two and three agree
module scs_edge_sync (
  input  wire logic MCLK,
  input  wire logic RST_N,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic       rise_reg;
  logic       rise_next;

  // shift and filter
  always_comb begin
    sh_next  = {sh_reg[1:0], din};
    lvl_next = lvl_reg;
    if (sh_reg[1] == sh_reg[2]) begin
      lvl_next = sh_reg[2];
    end
    rise_next = lvl_next & ~lvl_reg;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sh_reg   <= 3'h0;
      lvl_reg  <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      lvl_reg  <= lvl_next;
      rise_reg <= rise_next;
    end
  end

  assign level = lvl_reg;
  assign rise  = rise_reg;
endmodule

// File: test/scs_xosc_model.sv
`timescale 1ns/1ps
// far-side clock source on the second crystal terminal
module scs_xosc_model #(
  parameter int HALF_NS = 40
) (
  input  wire logic run,
  output logic      xtal_b
);
  initial xtal_b = 1'b0;
  // idle source: pin held low by its port latch
  // source within programmed range
  // pin is only driven as a clock input from this side
  always begin
    if (run) begin
      #(HALF_NS) xtal_b = ~xtal_b;
    end else begin
      xtal_b = 1'b0;
      @(posedge run);
    end
  end
endmodule

// File: test/system_clock_source_select_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module system_clock_source_select_bench;
  import scs_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} scs_row_t;
  logic       MCLK, RST_N, WR, RD, XTAL_B_IN, CORE_CLK_OUT, EXT_CLK_OUT;
  logic       XTAL_A_CLAIM, XTAL_B_CLAIM, INT_OSC_ON, run;
  logic [7:0] ADDR, WDATA, RDATA, d;
  logic [6:0] TRIM_STRAP, INT_TRIM;
  logic [2:0] EXT_FREQ_CTRL;
  int         err_total = 0;
  int         checks_done = 0;
  int         n;
  // write data beside what reads back; reserved bits must drop out
  // trim rows test storage only; no oscillator frequency is modelled
  scs_row_t rows [8] = '{'{8'hb2, 8'he7, 8'h17}, '{8'hb2, 8'h14, 8'h14},
    '{8'hb3, 8'hff, 8'h7f}, '{8'hb3, 8'h2a, 8'h2a}, '{8'hb1, 8'h0f, 8'h07},
    '{8'hb1, 8'h5d, 8'h55}, '{8'hb1, 8'h00, 8'h00}, '{8'h00, 8'hff, 8'h00}};

  scs_top DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TRIM_STRAP(TRIM_STRAP), .XTAL_B_IN(XTAL_B_IN),
    .CORE_CLK_OUT(CORE_CLK_OUT), .EXT_CLK_OUT(EXT_CLK_OUT),
    .XTAL_A_CLAIM(XTAL_A_CLAIM), .XTAL_B_CLAIM(XTAL_B_CLAIM),
    .EXT_FREQ_CTRL(EXT_FREQ_CTRL), .INT_OSC_ON(INT_OSC_ON), .INT_TRIM(INT_TRIM));
  scs_xosc_model #(.HALF_NS(40)) xosc (.run(run), .xtal_b(XTAL_B_IN));

  // 100 MHz system clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= w;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 r = RDATA;
  endtask

  // rising edges of the core or peripheral clock over a span
  task automatic count(input int cyc, input logic core, output int r);
    logic last;
    r = 0;
    // step off the edge so the value launched there is seen
    #1;
    last = core ? CORE_CLK_OUT : EXT_CLK_OUT;
    repeat (cyc) begin
      @(posedge MCLK);
      #1;
      if ((core ? CORE_CLK_OUT : EXT_CLK_OUT) && !last) r++;
      last = core ? CORE_CLK_OUT : EXT_CLK_OUT;
    end
  endtask

  task automatic do_reset(input logic [6:0] strap);
    TRIM_STRAP <= strap;
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (30) @(posedge MCLK);
  endtask

  // watchdog, well beyond the expected run length
  initial begin
    repeat (40000) @(posedge MCLK);
    err_total++;
    $display("Error watchdog expired");
    give_verdict();
  end

  // main sequence
  initial begin
    RST_N = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h00;
    WDATA = 8'h00;
    TRIM_STRAP = 7'h2a;
    run = 1'b0;
    do_reset(7'h2a);
    rd(ADDR_INT_CTRL, d);
    `CHK("ctrl reset", INT_CTRL_RST, d);
    rd(ADDR_EXT_CTRL, d);
    `CHK("ext reset", EXT_CTRL_RST, d);
    rd(ADDR_INT_TRIM, d);
    `CHK("trim strap", 8'h2a, d);
    `CHK("trim out", 7'h2a, INT_TRIM);
    count(256, 1'b1, n);
    `CHK("div8 at reset", 1'b1, n >= 15 && n <= 17);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      `CHK("register row", rows[i].r, d);
      if (rows[i].a == ADDR_EXT_CTRL) `CHK("freq field", rows[i].w[2:0], EXT_FREQ_CTRL);
    end
    $display("test registers done");
    // every divide code; rises over 256 cycles scale inversely with the divisor
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_INT_CTRL, 8'h04 | 8'(c));
      repeat (40) @(posedge MCLK);
      count(256, 1'b1, n);
      `CHK("divide rate", 1'b1, n * (8 >> c) >= 120 && n * (8 >> c) <= 136);
    end
    $display("test divider done");
    wr(ADDR_INT_CTRL, 8'h00);
    repeat (30) @(posedge MCLK);
    rd(ADDR_INT_CTRL, d);
    `CHK("ready when off", 8'h00, d);
    `CHK("osc off", 1'b0, INT_OSC_ON);
    wr(ADDR_INT_CTRL, 8'h07);
    repeat (30) @(posedge MCLK);
    rd(ADDR_INT_CTRL, d);
    `CHK("enable and select", 8'h17, d);
    `CHK("osc on", 1'b1, INT_OSC_ON);
    $display("test enable done");
    run = 1'b1;
    wr(ADDR_EXT_CTRL, 8'h67);
    rd(ADDR_EXT_CTRL, d);
    `CHK("crystal early", 8'h67, d);
    `CHK("claims crystal", 2'b11, {XTAL_A_CLAIM, XTAL_B_CLAIM});
    // no fixed 1 ms wait; the modelled settle count is far shorter
    n = 0;
    while (d[7] !== 1'b1 && n < 2000) begin
      rd(ADDR_EXT_CTRL, d);
      n++;
    end
    `CHK("crystal valid", 8'he7, d);
    count(800, 1'b0, n);
    `CHK("peripheral clock", 1'b1, n >= 98 && n <= 102);
    // switch only after the crystal has settled
    wr(ADDR_INT_CTRL, 8'h0f);
    repeat (40) @(posedge MCLK);
    count(800, 1'b1, n);
    `CHK("core from crystal", 1'b1, n >= 98 && n <= 102);
    wr(ADDR_EXT_CTRL, 8'h77);
    repeat (40) @(posedge MCLK);
    count(800, 1'b1, n);
    `CHK("crystal half", 1'b1, n >= 48 && n <= 52);
    wr(ADDR_EXT_CTRL, 8'h32);
    rd(ADDR_EXT_CTRL, d);
    `CHK("cmos no valid", 8'h32, d);
    `CHK("claims one pin", 2'b01, {XTAL_A_CLAIM, XTAL_B_CLAIM});
    repeat (40) @(posedge MCLK);
    count(800, 1'b1, n);
    `CHK("cmos half", 1'b1, n >= 48 && n <= 52);
    wr(ADDR_EXT_CTRL, 8'h22);
    repeat (40) @(posedge MCLK);
    count(800, 1'b1, n);
    `CHK("cmos full", 1'b1, n >= 98 && n <= 102);
    $display("test external done");
    // reset in mid-run while the external source drives the core
    do_reset(7'h55);
    rd(ADDR_INT_CTRL, d);
    `CHK("ctrl second reset", INT_CTRL_RST, d);
    rd(ADDR_INT_TRIM, d);
    `CHK("trim new strap", 8'h55, d);
    count(256, 1'b1, n);
    `CHK("div8 again", 1'b1, n >= 15 && n <= 17);
    `CHK("trim out again", 7'h55, INT_TRIM);
    $display("test second reset done");
    // RC mode halves the pin clock; only terminal b is taken
    wr(ADDR_EXT_CTRL, 8'h42);
    repeat (40) @(posedge MCLK);
    count(800, 1'b0, n);
    `CHK("rc half", 1'b1, n >= 48 && n <= 52);
    `CHK("rc claims", 2'b01, {XTAL_A_CLAIM, XTAL_B_CLAIM});
    // circuit off: peripheral clock parked low, no pins taken
    wr(ADDR_EXT_CTRL, 8'h12);
    repeat (40) @(posedge MCLK);
    count(800, 1'b0, n);
    `CHK("off quiet", 0, n);
    `CHK("off claims", 2'b00, {XTAL_A_CLAIM, XTAL_B_CLAIM});
    $display("test modes done");
    give_verdict();
  end
endmodule
